// ### backplane_segment_control_regs.sv
// status/command bank for one backplane segment, reached by index/data ports
// How it works
// - status bit 5 reads one while the segment is held in reset
// - status bit 4 unlocks command writes; zero makes command read-only
// - owner mode: status bit 3 shows segment quiesced, arbiter locked, bus idle
// - drone mode: status bit 3 shows handover requested, clears when done
// - rise of status bit 3 or 2 sets the segment change flag
// - status bit 2 sets on owner/drone mode change, write one clears
// - status bit 1 reads one in owner mode, zero in drone
// - status bit 0 reads one in a redundant host slot
// - command resets on power loss or master reset; status on power loss
// - command bit 5 reads one while the arbiter is enabled
// - drone mode: command bit 5 ignores writes and stays zero
// - owner mode: command bit 5 write one enables, zero locks arbiter
// - command bits 5 and 4 clear on master reset or slot enable inactive
// - command bit 4 enables backplane interrupts when owner; unwritable as drone
// - command bit 3 requests switchover; blocked while mode change set
// - command bit 3 clears on master reset, mode change, or redundant_host_n low
// - redundant drone: writing bit 2 withdraws alternate slot enable
// - redundant owner: writing bit 2 asserts alternate slot enable
// - command bit 1 locks mode; owner keeps arbiter on fault
// - locked drone ignores mode change requests and never becomes owner
// - bit 0 masks backplane reset in owner mode; drone never drives it
// - index port at E6h selects, data port at E7h accesses registers
// - change flags clear on write one; unmasked set flag raises interrupt
`include "segment_ctrl_map.svh"
module backplane_segment_control_regs (
    // clock, power-good reset and master reset
    input wire logic core_clk_i,
    input wire logic arst_n_i,
    input wire logic master_reset_i,
    // i/o port access, one-cycle strobes
    input wire logic io_wr_i,
    input wire logic io_rd_i,
    input wire logic [7:0] io_addr_i,
    input wire logic [7:0] io_wdata_i,
    output logic [7:0] io_rdata_o,
    output logic io_rvalid_o,
    // segment controller state
    input wire logic owner_mode_i,
    input wire logic redundant_host_n_i,
    input wire logic seg_in_reset_i,
    input wire logic seg_quiesced_i,
    input wire logic handover_req_i,
    input wire logic system_slot_enable_n_i,
    input wire logic fault_i,
    input wire logic mode_change_req_i,
    input wire logic mode_lock_preset_i,
    input wire logic seg_b_status_change_i,
    input wire logic [7:0] seg_b_status_i,
    // segment controller controls
    output logic arbiter_enable_o,
    output logic backplane_irq_en_o,
    output logic switchover_req_o,
    output logic alternate_slot_enable_n_o,
    output logic backplane_rst_n_o,
    output logic take_owner_o,
    output logic irq_o
);
    logic [2:0] index_r, index_nxt;
    logic unlock_r, unlock_nxt;
    logic [5:0] cmd_r, cmd_nxt;
    logic alt_en_r, alt_en_nxt;
    logic owner_prev_r, owner_prev_nxt;
    logic [2:0] int_mask_r, int_mask_nxt;
    logic [7:0] rdata_r, rdata_nxt;
    logic rvalid_r, rvalid_nxt;
    segment_ctrl_pkg::acc_state_t acc_r, acc_nxt;
    logic mode_chg, rise_q, rise_mc, flag_a, flag_b;
    logic wr_data, wr_int, wr_status, wr_cmd, cmd_ok, redundant, bit3;
    logic [7:0] status_v, int_v;

    assign redundant = ~redundant_host_n_i;
    // quiesce in owner mode, handover request in drone mode
    assign bit3 = owner_mode_i ? seg_quiesced_i : handover_req_i;
    assign wr_data = io_wr_i && io_addr_i == `FUNCTION_DATA_PORT_ADDR;
    assign wr_int = io_wr_i && io_addr_i == `INT_STATUS_ADDR;
    assign wr_status = wr_data && index_r == `SEGMENT_A_STATUS_IDX;
    assign wr_cmd = wr_data && index_r == `SEGMENT_A_COMMAND_IDX;
    assign cmd_ok = wr_cmd && unlock_r;

    always_comb begin
        status_v = 8'h00;
        status_v[`ST_SEG_RESET] = seg_in_reset_i;
        status_v[`ST_WR_UNLOCK] = unlock_r;
        status_v[`ST_QUIESCE_HANDOVER] = bit3;
        status_v[`ST_MODE_CHANGE] = mode_chg;
        status_v[`ST_OWNER] = owner_mode_i;
        status_v[`ST_REDUNDANT] = redundant;
        int_v = 8'h00;
        int_v[`INT_A_FLAG] = flag_a;
        int_v[`INT_A_MASK] = int_mask_r[0];
        int_v[`INT_B_FLAG] = flag_b;
        int_v[`INT_B_MASK] = int_mask_r[1];
        int_v[5] = int_mask_r[2];
    end

    // mode change status: owner level edge either way sets it
    change_flag u_mode_chg (
        .core_clk_i(core_clk_i),
        .arst_n_i(arst_n_i),
        .set_i(owner_mode_i != owner_prev_r),
        .clr_i(wr_status && io_wdata_i[`ST_MODE_CHANGE]),
        .flag_o(mode_chg)
    );
    rise_detect u_rise_q (
        .core_clk_i(core_clk_i),
        .arst_n_i(arst_n_i),
        .level_i(bit3),
        .rise_o(rise_q)
    );
    rise_detect u_rise_mc (
        .core_clk_i(core_clk_i),
        .arst_n_i(arst_n_i),
        .level_i(mode_chg),
        .rise_o(rise_mc)
    );
    // segment change flags; a set in the clear cycle is kept
    change_flag u_flag_a (
        .core_clk_i(core_clk_i),
        .arst_n_i(arst_n_i),
        .set_i(rise_q | rise_mc),
        .clr_i(wr_int && io_wdata_i[`INT_A_FLAG]),
        .flag_o(flag_a)
    );
    change_flag u_flag_b (
        .core_clk_i(core_clk_i),
        .arst_n_i(arst_n_i),
        .set_i(seg_b_status_change_i),
        .clr_i(wr_int && io_wdata_i[`INT_B_FLAG]),
        .flag_o(flag_b)
    );

    always_comb begin
        index_nxt = index_r;
        unlock_nxt = unlock_r;
        int_mask_nxt = int_mask_r;
        owner_prev_nxt = owner_mode_i;
        if (io_wr_i && io_addr_i == `FUNCTION_INDEX_PORT_ADDR) begin
            index_nxt = io_wdata_i[2:0];
        end
        if (wr_status) begin
            unlock_nxt = io_wdata_i[`ST_WR_UNLOCK];
        end
        if (wr_int) begin
            int_mask_nxt = {io_wdata_i[5], io_wdata_i[`INT_B_MASK],
                            io_wdata_i[`INT_A_MASK]};
        end
    end

    always_comb begin
        cmd_nxt = cmd_r;
        alt_en_nxt = alt_en_r;
        if (cmd_ok) begin
            if (owner_mode_i) begin
                cmd_nxt[`CMD_ARB_EN] = io_wdata_i[`CMD_ARB_EN];
                cmd_nxt[`CMD_IRQ_EN] = io_wdata_i[`CMD_IRQ_EN];
            end
            if (!mode_chg) begin
                cmd_nxt[`CMD_SWITCHOVER] = io_wdata_i[`CMD_SWITCHOVER];
            end
            cmd_nxt[`CMD_MODE_LOCK] = io_wdata_i[`CMD_MODE_LOCK];
            cmd_nxt[`CMD_RST_MASK] = io_wdata_i[`CMD_RST_MASK];
            if (io_wdata_i[`CMD_TRANSFER_NOW] && redundant) begin
                // write-one action: owner asserts, drone withdraws
                alt_en_nxt = owner_mode_i;
            end
        end
        if (!owner_mode_i) begin
            cmd_nxt[`CMD_ARB_EN] = 1'b0;
        end
        if (fault_i && owner_mode_i && !cmd_r[`CMD_MODE_LOCK]) begin
            cmd_nxt[`CMD_ARB_EN] = 1'b0;
        end
        if (system_slot_enable_n_i) begin
            cmd_nxt[`CMD_ARB_EN] = 1'b0;
            cmd_nxt[`CMD_IRQ_EN] = 1'b0;
        end
        if (mode_chg || !redundant_host_n_i) begin
            cmd_nxt[`CMD_SWITCHOVER] = 1'b0;
        end
        cmd_nxt[`CMD_TRANSFER_NOW] = 1'b0;
        if (master_reset_i) begin
            cmd_nxt = 6'(`COMMAND_RESET);
            cmd_nxt[`CMD_MODE_LOCK] = mode_lock_preset_i;
        end
    end

    // one-cycle read answer
    always_comb begin
        acc_nxt = segment_ctrl_pkg::ACC_IDLE;
        rdata_nxt = rdata_r;
        rvalid_nxt = 1'b0;
        if (io_wr_i) begin
            acc_nxt = segment_ctrl_pkg::ACC_WRITE;
        end else if (io_rd_i) begin
            acc_nxt = segment_ctrl_pkg::ACC_READ;
            rvalid_nxt = 1'b1;
            rdata_nxt = 8'h00;
            case (io_addr_i)
                `FUNCTION_INDEX_PORT_ADDR: rdata_nxt = {5'h00, index_r};
                `INT_STATUS_ADDR: rdata_nxt = int_v;
                `FUNCTION_DATA_PORT_ADDR: begin
                    case (index_r)
                        `SEGMENT_A_STATUS_IDX: rdata_nxt = status_v;
                        `SEGMENT_A_COMMAND_IDX: rdata_nxt = {2'h0, cmd_r};
                        `SEGMENT_B_STATUS_IDX: rdata_nxt = seg_b_status_i;
                        default: rdata_nxt = 8'h00;
                    endcase
                end
                default: rdata_nxt = 8'h00;
            endcase
        end
    end

    // status bank resets on power-good only; master reset spares it
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            index_r <= `INDEX_RESET;
            unlock_r <= 1'b0;
            cmd_r <= 6'h00;
            alt_en_r <= 1'b0;
            owner_prev_r <= 1'b0;
            int_mask_r <= 3'h7;
            rdata_r <= 8'h00;
            rvalid_r <= 1'b0;
            acc_r <= segment_ctrl_pkg::ACC_IDLE;
        end else begin
            index_r <= index_nxt;
            unlock_r <= unlock_nxt;
            cmd_r <= cmd_nxt;
            alt_en_r <= alt_en_nxt;
            owner_prev_r <= owner_prev_nxt;
            int_mask_r <= int_mask_nxt;
            rdata_r <= rdata_nxt;
            rvalid_r <= rvalid_nxt;
            acc_r <= acc_nxt;
        end
    end

    assign io_rdata_o = rdata_r;
    assign io_rvalid_o = rvalid_r;
    assign arbiter_enable_o = cmd_r[`CMD_ARB_EN];
    assign backplane_irq_en_o = cmd_r[`CMD_IRQ_EN] & owner_mode_i;
    assign switchover_req_o = cmd_r[`CMD_SWITCHOVER];
    assign alternate_slot_enable_n_o = ~alt_en_r;
    // drone never drives reset; owner drives it unless masked
    assign backplane_rst_n_o = ~(seg_in_reset_i & owner_mode_i
                                & ~cmd_r[`CMD_RST_MASK]);
    // a locked drone never takes ownership
    assign take_owner_o = mode_change_req_i & ~owner_mode_i
                          & ~cmd_r[`CMD_MODE_LOCK];
    assign irq_o = (flag_a & ~int_mask_r[0])
                   | (flag_b & ~int_mask_r[1]);

    property p_cmd_locked;
        @(posedge core_clk_i) disable iff (!arst_n_i)
        (wr_cmd && !unlock_r && !master_reset_i && !system_slot_enable_n_i
         && !mode_chg && redundant_host_n_i && !fault_i)
        |=> cmd_r == $past(cmd_r);
    endproperty
    a_cmd_locked: assert property (p_cmd_locked)
        else $error("command changed while locked");
    property p_drone_arb;
        @(posedge core_clk_i) disable iff (!arst_n_i)
        !owner_mode_i |=> !arbiter_enable_o;
    endproperty
    a_drone_arb: assert property (p_drone_arb)
        else $error("arbiter enabled in drone mode");
    property p_slot_clear;
        @(posedge core_clk_i) disable iff (!arst_n_i)
        system_slot_enable_n_i |=> !cmd_r[`CMD_ARB_EN] && !cmd_r[`CMD_IRQ_EN];
    endproperty
    a_slot_clear: assert property (p_slot_clear)
        else $error("arbiter or irq enable survived slot disable");
    property p_sw_clear;
        @(posedge core_clk_i) disable iff (!arst_n_i)
        (mode_chg || !redundant_host_n_i || master_reset_i)
        |=> !switchover_req_o;
    endproperty
    a_sw_clear: assert property (p_sw_clear)
        else $error("switchover request not cleared");
    property p_flag_set;
        @(posedge core_clk_i) disable iff (!arst_n_i)
        $rose(bit3) |=> flag_a;
    endproperty
    a_flag_set: assert property (p_flag_set)
        else $error("change flag not set on bit3 rise");
    property p_irq;
        @(posedge core_clk_i) disable iff (!arst_n_i)
        (flag_a && !int_mask_r[0]) |-> irq_o;
    endproperty
    a_irq: assert property (p_irq)
        else $error("unmasked flag without interrupt");
    property p_drone_rst;
        @(posedge core_clk_i) disable iff (!arst_n_i)
        !owner_mode_i |-> backplane_rst_n_o;
    endproperty
    a_drone_rst: assert property (p_drone_rst)
        else $error("drone drove backplane reset");
    property p_mode_chg;
        @(posedge core_clk_i) disable iff (!arst_n_i)
        (owner_mode_i != $past(owner_mode_i)) |=> mode_chg;
    endproperty
    a_mode_chg: assert property (p_mode_chg)
        else $error("mode change not flagged");
    property p_lock_drone;
        @(posedge core_clk_i) disable iff (!arst_n_i)
        cmd_r[`CMD_MODE_LOCK] |-> !take_owner_o;
    endproperty
    a_lock_drone: assert property (p_lock_drone)
        else $error("locked drone took ownership");
    property p_read_answer;
        @(posedge core_clk_i) disable iff (!arst_n_i)
        (io_rd_i && !io_wr_i) |=> io_rvalid_o
            && acc_r == segment_ctrl_pkg::ACC_READ;
    endproperty
    a_read_answer: assert property (p_read_answer)
        else $error("read not answered in the next cycle");
    property p_alt_owner;
        @(posedge core_clk_i) disable iff (!arst_n_i)
        (cmd_ok && io_wdata_i[`CMD_TRANSFER_NOW] && !redundant_host_n_i
         && owner_mode_i) |=> !alternate_slot_enable_n_o;
    endproperty
    a_alt_owner: assert property (p_alt_owner)
        else $error("owner transfer did not assert alternate enable");
    property p_alt_drone;
        @(posedge core_clk_i) disable iff (!arst_n_i)
        (cmd_ok && io_wdata_i[`CMD_TRANSFER_NOW] && !redundant_host_n_i
         && !owner_mode_i) |=> alternate_slot_enable_n_o;
    endproperty
    a_alt_drone: assert property (p_alt_drone)
        else $error("drone transfer did not withdraw alternate enable");
    property p_master_reset_cmd;
        @(posedge core_clk_i) disable iff (!arst_n_i)
        master_reset_i |=> !arbiter_enable_o && !switchover_req_o
            && !backplane_irq_en_o && !cmd_r[`CMD_RST_MASK];
    endproperty
    a_master_reset_cmd: assert property (p_master_reset_cmd)
        else $error("command bits survived master reset");
    property p_swo_blocked;
        @(posedge core_clk_i) disable iff (!arst_n_i)
        (cmd_ok && mode_chg && !switchover_req_o) |=> !switchover_req_o;
    endproperty
    a_swo_blocked: assert property (p_swo_blocked)
        else $error("switchover written while mode change set");
    c_unlock_write: cover property (@(posedge core_clk_i) cmd_ok);
    c_takeover: cover property (@(posedge core_clk_i) $fell(alt_en_r)
                                || $rose(alt_en_r));
    c_irq: cover property (@(posedge core_clk_i) $rose(irq_o));
endmodule : backplane_segment_control_regs

// ### change_flag.sv
// sticky write-one-to-clear flag where a set beats a clear
module change_flag (
    // clock and reset
    input wire logic core_clk_i,
    input wire logic arst_n_i,
    // set and clear
    input wire logic set_i,
    input wire logic clr_i,
    output logic flag_o
);
    logic flag_r;
    logic flag_nxt;
    always_comb begin
        flag_nxt = flag_r;
        if (clr_i) begin
            flag_nxt = 1'b0;
        end
        if (set_i) begin
            flag_nxt = 1'b1;
        end
    end
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            flag_r <= 1'b0;
        end else begin
            flag_r <= flag_nxt;
        end
    end
    assign flag_o = flag_r;
endmodule : change_flag

// ### rise_detect.sv
// rising edge detector for one status level
module rise_detect (
    // clock and reset
    input wire logic core_clk_i,
    input wire logic arst_n_i,
    // level in, pulse out
    input wire logic level_i,
    output logic rise_o
);
    logic prev_r;
    logic prev_nxt;
    always_comb begin
        prev_nxt = level_i;
    end
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            prev_r <= 1'b0;
        end else begin
            prev_r <= prev_nxt;
        end
    end
    assign rise_o = level_i & ~prev_r;
endmodule : rise_detect

// ### segment_ctrl_map.svh
// register offsets, field positions and reset values for the segment control bank
`ifndef SEGMENT_CTRL_MAP_SVH
`define SEGMENT_CTRL_MAP_SVH
`define FUNCTION_INDEX_PORT_ADDR 8'he6
`define FUNCTION_DATA_PORT_ADDR 8'he7
`define INT_STATUS_ADDR 8'he8
`define SEGMENT_A_STATUS_IDX 3'h1
`define SEGMENT_A_COMMAND_IDX 3'h2
`define SEGMENT_B_STATUS_IDX 3'h3
`define INDEX_RESET 3'h0
`define STATUS_RESET 8'h00
`define COMMAND_RESET 8'h00
`define INT_RESET 8'h2a
`define ST_SEG_RESET 5
`define ST_WR_UNLOCK 4
`define ST_QUIESCE_HANDOVER 3
`define ST_MODE_CHANGE 2
`define ST_OWNER 1
`define ST_REDUNDANT 0
`define CMD_ARB_EN 5
`define CMD_IRQ_EN 4
`define CMD_SWITCHOVER 3
`define CMD_TRANSFER_NOW 2
`define CMD_MODE_LOCK 1
`define CMD_RST_MASK 0
`define INT_A_FLAG 0
`define INT_A_MASK 1
`define INT_B_FLAG 2
`define INT_B_MASK 3
`endif

// ### segment_ctrl_pkg.sv
// types shared by the segment control bank
package segment_ctrl_pkg;
    typedef enum logic [2:0] {
        ACC_IDLE = 3'b001,
        ACC_WRITE = 3'b010,
        ACC_READ = 3'b100
    } acc_state_t;
endpackage : segment_ctrl_pkg

// ### segment_host_model.sv
// far-side segment controller and host board model
module segment_host_model (
    // clock
    input wire logic core_clk_i,
    // promotion request from the bank
    input wire logic take_owner_i,
    // segment state towards the bank
    output logic own_o,
    output logic rh_n_o,
    output logic sir_o,
    output logic qsc_o,
    output logic hreq_o,
    output logic sse_n_o,
    output logic flt_o,
    output logic mcr_o,
    output logic lock_o,
    output logic bchg_o,
    output logic [7:0] bst_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // levels are set by the bench between edges, like a slow board
    initial begin
        own_o = 1'b0;
        rh_n_o = 1'b1;
        sir_o = 1'b0;
        qsc_o = 1'b0;
        hreq_o = 1'b0;
        sse_n_o = 1'b0;
        flt_o = 1'b0;
        mcr_o = 1'b0;
        lock_o = 1'b1; // on-board switch presets mode lock
        bchg_o = 1'b0;
        bst_o = 8'h5a;
    end
    // promotion completes a pending handover
    always @(negedge core_clk_i) begin
        if (take_owner_i) begin
            own_o = 1'b1;
            hreq_o = 1'b0;
        end
    end
endmodule : segment_host_model

// ### test_backplane_segment_control_regs.sv
// self-checking bench for the segment control register bank
`include "segment_ctrl_map.svh"
module test_backplane_segment_control_regs;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, rst_n, master_reset, wr_s, rd_s, rvalid;
    logic [7:0] addr, wdata, rdata, bst, v;
    logic own, rh_n, sir, qsc, hreq, sse_n, flt, mcr, lock, bchg;
    logic arb, irqen, swo, alt_n, bprst_n, take, irq;
    int err_count = 0;
    int n_checks = 0;

    backplane_segment_control_regs u_backplane_segment_control_regs (
        .core_clk_i(clk), .arst_n_i(rst_n), .master_reset_i(master_reset),
        .io_wr_i(wr_s), .io_rd_i(rd_s), .io_addr_i(addr),
        .io_wdata_i(wdata), .io_rdata_o(rdata), .io_rvalid_o(rvalid),
        .owner_mode_i(own), .redundant_host_n_i(rh_n),
        .seg_in_reset_i(sir), .seg_quiesced_i(qsc),
        .handover_req_i(hreq), .system_slot_enable_n_i(sse_n),
        .fault_i(flt), .mode_change_req_i(mcr),
        .mode_lock_preset_i(lock), .seg_b_status_change_i(bchg),
        .seg_b_status_i(bst), .arbiter_enable_o(arb),
        .backplane_irq_en_o(irqen), .switchover_req_o(swo),
        .alternate_slot_enable_n_o(alt_n), .backplane_rst_n_o(bprst_n),
        .take_owner_o(take), .irq_o(irq));

    segment_host_model u_host (
        .core_clk_i(clk), .take_owner_i(take), .own_o(own),
        .rh_n_o(rh_n), .sir_o(sir), .qsc_o(qsc), .hreq_o(hreq),
        .sse_n_o(sse_n), .flt_o(flt), .mcr_o(mcr), .lock_o(lock),
        .bchg_o(bchg), .bst_o(bst));

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    task automatic end_of_test();
        if (err_count == 0 && n_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : end_of_test

    task automatic chk(input string what, input logic [7:0] seen,
            input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    task automatic chb(input string what, input logic seen, input logic exp);
        chk(what, {7'h00, seen}, {7'h00, exp});
    endtask : chb

    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask : cyc

    // strobe raised after a falling edge, held across one rising edge
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        wr_s = 1'b1;
        addr = a;
        wdata = d;
        @(negedge clk);
        wr_s = 1'b0;
    endtask : wr

    task automatic ck(input logic [7:0] a, input logic [7:0] exp,
            input string what);
        int n;
        @(negedge clk);
        rd_s = 1'b1;
        addr = a;
        @(negedge clk);
        rd_s = 1'b0;
        n = 0;
        while (rvalid !== 1'b1 && n < 4) begin
            @(negedge clk);
            n++;
        end
        chb("read valid", rvalid, 1'b1);
        chk(what, rdata, exp);
    endtask : ck

    task automatic wix(input logic [7:0] i, input logic [7:0] d);
        wr(`FUNCTION_INDEX_PORT_ADDR, i);
        wr(`FUNCTION_DATA_PORT_ADDR, d);
    endtask : wix

    task automatic cix(input logic [7:0] i, input logic [7:0] exp,
            input string what);
        wr(`FUNCTION_INDEX_PORT_ADDR, i);
        ck(`FUNCTION_DATA_PORT_ADDR, exp, what);
    endtask : cix

    initial begin
        #100000;
        err_count++;
        end_of_test();
    end

    initial begin
        rst_n = 1'b0;
        master_reset = 1'b0;
        wr_s = 1'b0;
        rd_s = 1'b0;
        addr = 8'h00;
        wdata = 8'h00;
        repeat (12) @(posedge clk);
        @(negedge clk);
        rst_n = 1'b1;
        ck(`INT_STATUS_ADDR, 8'h2a, "int reset");
        cix(8'h00, 8'h00, "reserved idx");
        cix(8'h05, 8'h00, "unmapped idx");
        cix(8'h01, 8'h00, "status reset");
        cix(8'h02, 8'h00, "command reset");
        cix(8'h03, 8'h5a, "seg b status");
        @(negedge clk);
        u_host.bchg_o = 1'b1;
        @(negedge clk);
        u_host.bchg_o = 1'b0;
        ck(`INT_STATUS_ADDR, 8'h2e, "flag b");
        wr(`INT_STATUS_ADDR, 8'h04);
        ck(`INT_STATUS_ADDR, 8'h00, "flag b clear");
        wix(8'h02, 8'h3f);
        cix(8'h02, 8'h00, "locked cmd");
        u_host.sir_o = 1'b1;
        u_host.rh_n_o = 1'b0;
        cix(8'h01, 8'h21, "status reset rh");
        chb("drone rst_n", bprst_n, 1'b1);
        u_host.sir_o = 1'b0;
        wix(8'h01, 8'h10);
        wix(8'h02, 8'h3a);
        cix(8'h02, 8'h02, "drone cmd");
        u_host.hreq_o = 1'b1;
        cix(8'h01, 8'h19, "handover");
        chb("irq set", irq, 1'b1);
        wr(`INT_STATUS_ADDR, 8'h01);
        chb("irq clear", irq, 1'b0);
        u_host.hreq_o = 1'b0;
        u_host.mcr_o = 1'b1;
        cyc(2);
        chb("locked take", take, 1'b0);
        wix(8'h02, 8'h00);
        cyc(3);
        u_host.mcr_o = 1'b0;
        cix(8'h01, 8'h17, "promoted");
        ck(`INT_STATUS_ADDR, 8'h01, "mode flag");
        wr(`INT_STATUS_ADDR, 8'h01);
        wix(8'h01, 8'h14);
        cix(8'h01, 8'h13, "mode w1c");
        wix(8'h02, 8'h31);
        cix(8'h02, 8'h31, "owner cmd");
        chb("arbiter", arb, 1'b1);
        chb("bp irq en", irqen, 1'b1);
        u_host.sir_o = 1'b1;
        cyc(1);
        chb("masked rst_n", bprst_n, 1'b1);
        wix(8'h02, 8'h30);
        chb("owner rst_n", bprst_n, 1'b0);
        u_host.sir_o = 1'b0;
        u_host.flt_o = 1'b1;
        cix(8'h02, 8'h10, "fault unlocked");
        u_host.flt_o = 1'b0;
        wix(8'h02, 8'h32);
        u_host.flt_o = 1'b1;
        cix(8'h02, 8'h32, "fault locked");
        u_host.flt_o = 1'b0;
        u_host.sse_n_o = 1'b1;
        cix(8'h02, 8'h02, "slot disabled");
        u_host.sse_n_o = 1'b0;
        u_host.qsc_o = 1'b1;
        cix(8'h01, 8'h1b, "quiesced");
        ck(`INT_STATUS_ADDR, 8'h01, "quiesce flag");
        wr(`INT_STATUS_ADDR, 8'h01);
        u_host.qsc_o = 1'b0;
        wix(8'h02, 8'h06);
        chb("alt owner", alt_n, 1'b0);
        cix(8'h02, 8'h02, "transfer reads");
        u_host.rh_n_o = 1'b1;
        wix(8'h02, 8'h0a);
        chb("switchover", swo, 1'b1);
        u_host.rh_n_o = 1'b0;
        cyc(2);
        chb("rh clears swo", swo, 1'b0);
        u_host.rh_n_o = 1'b1;
        wix(8'h02, 8'h0a);
        u_host.own_o = 1'b0;
        cyc(3);
        chb("mode clears swo", swo, 1'b0);
        wix(8'h02, 8'h0a);
        chb("swo blocked", swo, 1'b0);
        @(negedge clk);
        master_reset = 1'b1;
        @(negedge clk);
        master_reset = 1'b0;
        cix(8'h02, 8'h02, "master reset cmd");
        cix(8'h01, 8'h14, "master reset st");
        u_host.rh_n_o = 1'b0;
        wix(8'h02, 8'h04);
        chb("alt drone", alt_n, 1'b1);
        end_of_test();
    end
endmodule : test_backplane_segment_control_regs
